// *** spp_defines.svh ***
`ifndef SPP_DEFINES_SVH
`define SPP_DEFINES_SVH
// register byte offsets
`define SPP_OFF_CTRL 8'h00
`define SPP_OFF_DELIM 8'h04
`define SPP_OFF_PLEN 8'h08
`define SPP_OFF_IDLE 8'h0c
`define SPP_OFF_DPORT 8'h10
`define SPP_OFF_CPORT 8'h14
`define SPP_OFF_STAT 8'h18
`define SPP_OFF_LCMD 8'h1c
// control field positions
`define SPP_B_D1EN 0
`define SPP_B_D2EN 1
`define SPP_B_PROC 2
`define SPP_B_SKIP 4
`define SPP_B_DRV 5
`define SPP_B_LDHI 6
`define SPP_B_MSEL 7
`define SPP_B_RTS 8
`define SPP_B_DTR 9
// reset values and limits
`define SPP_CTRL_RST 10'h040
`define SPP_DPORT_RST 14'h0fa1
`define SPP_DPORT_MAX 32'h0000270f
`define SPP_CPORT_RST 16'h03c6
`define SPP_PLEN_MAX 32'h00000400
`define SPP_BUF_FULL 11'h400
// delimiter handling codes
`define SPP_PROC_KEEP 2'h0
`define SPP_PROC_STRIP 2'h3
// timing
`define SPP_MS_NS 1000000
`define SPP_CLK_NS 50
`endif

// *** spp_pkg.sv ***
package spp_pkg;
   typedef enum logic {spp_collect, spp_drain} spp_state_t;
endpackage

// *** spp_packer.sv ***
// Function
// - length limit zero: release only on delimiter, full buffer or idle gap; resets to zero
// - length limit 1..1024: release once byte count reaches it
// - one delimiter byte ends packet; both need two bytes in sequence
// - with delimiters on and zero length limit and idle gap, keep collecting until full or sequence seen
// - both delimiter enables come out of reset off
// - link down and level low: selected modem line driven low
// - link down and level high (reset): selected modem line held high
// - skipping off (reset): any unresponsive host halts all transmission
// - skipping on: keep sending to responsive hosts
// - driver control off (reset): drop every host control command
// - driver control on: accept commands, latest one overrides
// - data listen port 0..9999, default 4001
// - command port separate, default 966
// - delimiter handling: keep, wait one or two more bytes, or strip
// - nonzero idle gap in ms releases buffer; zero disables
`timescale 1ns/1ps
`include "spp_defines.svh"
module spp_packer #(
   parameter int MS_CYCLES = (`SPP_MS_NS + `SPP_CLK_NS - 1) / `SPP_CLK_NS
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   output logic rx_ready,
   output logic pkt_valid,
   output logic [7:0] pkt_data,
   output logic pkt_last,
   output logic [7:0] pkt_hosts,
   input wire logic pkt_ready,
   input wire logic [7:0] host_conn,
   input wire logic [7:0] host_resp,
   input wire logic cmd_valid,
   input wire logic [15:0] cmd_port,
   input wire logic [7:0] cmd_data,
   output logic ctl_cmd_stb,
   output logic [7:0] ctl_cmd,
   output logic [13:0] data_port,
   output logic [15:0] cmd_listen_port,
   input wire logic link_up,
   output logic rts,
   output logic dtr
);
   logic aw_rdy_q, w_rdy_q, bvalid_q, ar_rdy_q, rvalid_q;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q, rdata_q;
   logic [3:0] w_strb_q;
   logic [1:0] bresp_q, rresp_q;
   logic [9:0] ctrl_q;
   logic [15:0] delim_q, idle_q, cport_q;
   logic [10:0] plen_q;
   logic [13:0] dport_q;
   logic [7:0] lcmd_q;
   logic stb_q, rts_q, dtr_q;
   spp_pkg::spp_state_t st_q;
   logic [7:0] mem [0:1023];
   logic [10:0] count_q, n_q, rd_ptr_q;
   logic [1:0] extra_q;
   logic prev_d1_q, rx_rdy_q, pv_q, pl_q;
   logic [7:0] pd_q, ph_q;
   logic [14:0] pre_q;
   logic [15:0] ms_q;

   function automatic logic [31:0] spp_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // ---------------- bus slave ----------------
   logic do_wr, wr_ok;
   logic [31:0] wm_ctrl, wm_delim, wm_plen, wm_idle, wm_dport, wm_cport;
   assign do_wr = !aw_rdy_q && !w_rdy_q && !bvalid_q;
   assign wr_ok = aw_addr_q[1:0] == 2'h0 && aw_addr_q <= `SPP_OFF_CPORT;
   assign wm_ctrl = spp_merge({22'h0, ctrl_q}, w_data_q, w_strb_q);
   assign wm_delim = spp_merge({16'h0, delim_q}, w_data_q, w_strb_q);
   assign wm_plen = spp_merge({21'h0, plen_q}, w_data_q, w_strb_q);
   assign wm_idle = spp_merge({16'h0, idle_q}, w_data_q, w_strb_q);
   assign wm_dport = spp_merge({18'h0, dport_q}, w_data_q, w_strb_q);
   assign wm_cport = spp_merge({16'h0, cport_q}, w_data_q, w_strb_q);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         aw_rdy_q <= 1'b1;
         aw_addr_q <= 8'h00;
      end else if (s_axi_awvalid && aw_rdy_q) begin
         aw_rdy_q <= 1'b0;
         aw_addr_q <= s_axi_awaddr;
      end else if (bvalid_q && s_axi_bready) begin
         aw_rdy_q <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         w_rdy_q <= 1'b1;
         w_data_q <= 32'h0;
         w_strb_q <= 4'h0;
      end else if (s_axi_wvalid && w_rdy_q) begin
         w_rdy_q <= 1'b0;
         w_data_q <= s_axi_wdata;
         w_strb_q <= s_axi_wstrb;
      end else if (bvalid_q && s_axi_bready) begin
         w_rdy_q <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         bvalid_q <= 1'b0;
         bresp_q <= 2'h0;
      end else if (do_wr) begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_ok ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_q <= `SPP_CTRL_RST;
         delim_q <= 16'h0000;
         plen_q <= 11'h000;
         idle_q <= 16'h0000;
         dport_q <= `SPP_DPORT_RST;
         cport_q <= `SPP_CPORT_RST;
      end else if (do_wr) begin
         case (aw_addr_q)
            `SPP_OFF_CTRL: ctrl_q <= wm_ctrl[9:0];
            `SPP_OFF_DELIM: delim_q <= wm_delim[15:0];
            `SPP_OFF_PLEN: begin
               // out-of-range limits are dropped, keeping the old one
               if (wm_plen <= `SPP_PLEN_MAX) begin
                  plen_q <= wm_plen[10:0];
               end
            end
            `SPP_OFF_IDLE: idle_q <= wm_idle[15:0];
            `SPP_OFF_DPORT: begin
               if (wm_dport <= `SPP_DPORT_MAX) begin
                  dport_q <= wm_dport[13:0];
               end
            end
            `SPP_OFF_CPORT: cport_q <= wm_cport[15:0];
            default: ;
         endcase
      end
   end

   logic halt;
   logic [31:0] rd_mux;
   always_comb begin
      case (s_axi_araddr)
         `SPP_OFF_CTRL: rd_mux = {22'h0, ctrl_q};
         `SPP_OFF_DELIM: rd_mux = {16'h0, delim_q};
         `SPP_OFF_PLEN: rd_mux = {21'h0, plen_q};
         `SPP_OFF_IDLE: rd_mux = {16'h0, idle_q};
         `SPP_OFF_DPORT: rd_mux = {18'h0, dport_q};
         `SPP_OFF_CPORT: rd_mux = {16'h0, cport_q};
         `SPP_OFF_STAT: rd_mux = {18'h0, link_up, halt, st_q == spp_pkg::spp_drain, count_q};
         `SPP_OFF_LCMD: rd_mux = {24'h0, lcmd_q};
         default: rd_mux = 32'h0;
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ar_rdy_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0;
         rresp_q <= 2'h0;
      end else if (s_axi_arvalid && ar_rdy_q) begin
         ar_rdy_q <= 1'b0;
         rvalid_q <= 1'b1;
         rdata_q <= rd_mux;
         rresp_q <= (s_axi_araddr[1:0] == 2'h0 && s_axi_araddr <= `SPP_OFF_LCMD) ? 2'h0 : 2'h2;
      end else if (rvalid_q && s_axi_rready) begin
         ar_rdy_q <= 1'b1;
         rvalid_q <= 1'b0;
      end
   end

   // ---------------- packer ----------------
   logic d1en, d2en, skip;
   logic [1:0] proc;
   logic take, hit1, hit, strip, store, drop, rel, idle_fire, load, drain_done;
   logic [10:0] cnt_new, cnt_rel;
   assign d1en = ctrl_q[`SPP_B_D1EN];
   assign d2en = ctrl_q[`SPP_B_D2EN];
   assign proc = ctrl_q[`SPP_B_PROC +: 2];
   assign skip = ctrl_q[`SPP_B_SKIP];
   assign take = rx_valid && rx_rdy_q;
   assign hit1 = d1en && rx_data == delim_q[7:0];
   // second enable alone arms nothing; the first is the master switch
   assign hit = d2en ? (d1en && prev_d1_q && rx_data == delim_q[15:8]) : hit1;
   assign strip = proc == `SPP_PROC_STRIP;
   assign store = !(hit && strip);
   assign drop = hit && strip && d2en;
   assign cnt_new = count_q + {10'h0, store} - {10'h0, drop};
   assign cnt_rel = take ? cnt_new : count_q;
   assign idle_fire = idle_q != 16'h0 && ms_q == idle_q && count_q != 11'h0;
   // any mix of conditions lands in the one release below
   assign rel = (take && ((hit && (proc == `SPP_PROC_KEEP || strip))
                || (extra_q == 2'h1)
                || (plen_q != 11'h0 && cnt_new >= plen_q)
                || cnt_new == `SPP_BUF_FULL))
                || (!take && idle_fire);
   // an unresponsive host freezes everyone unless skipping is on
   assign halt = !skip && |(host_conn & ~host_resp);
   assign load = st_q == spp_pkg::spp_drain && (!pv_q || pkt_ready)
                 && rd_ptr_q != n_q && !halt;
   assign drain_done = st_q == spp_pkg::spp_drain && (!pv_q || pkt_ready) && rd_ptr_q == n_q;

   always_ff @(posedge clk) begin
      if (st_q == spp_pkg::spp_collect && take && store) begin
         mem[count_q[9:0] - {9'h0, drop}] <= rx_data;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_q <= spp_pkg::spp_collect;
         count_q <= 11'h0;
         n_q <= 11'h0;
         extra_q <= 2'h0;
         prev_d1_q <= 1'b0;
         rx_rdy_q <= 1'b1;
      end else begin
         case (st_q)
            spp_pkg::spp_collect: begin
               if (rel) begin
                  count_q <= 11'h0;
                  extra_q <= 2'h0;
                  prev_d1_q <= 1'b0;
                  if (cnt_rel != 11'h0) begin
                     st_q <= spp_pkg::spp_drain;
                     n_q <= cnt_rel;
                     rx_rdy_q <= 1'b0;
                  end
               end else if (take) begin
                  count_q <= cnt_new;
                  prev_d1_q <= hit1;
                  if (hit && !strip && proc != `SPP_PROC_KEEP) begin
                     extra_q <= proc;
                  end else if (extra_q != 2'h0) begin
                     extra_q <= extra_q - 2'h1;
                  end
               end
            end
            spp_pkg::spp_drain: begin
               if (drain_done) begin
                  st_q <= spp_pkg::spp_collect;
                  rx_rdy_q <= 1'b1;
               end
            end
            default: st_q <= spp_pkg::spp_collect;
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rd_ptr_q <= 11'h0;
         pv_q <= 1'b0;
         pd_q <= 8'h00;
         pl_q <= 1'b0;
         ph_q <= 8'h00;
      end else if (st_q == spp_pkg::spp_collect) begin
         rd_ptr_q <= 11'h0;
      end else if (load) begin
         pv_q <= 1'b1;
         pd_q <= mem[rd_ptr_q[9:0]];
         pl_q <= rd_ptr_q == n_q - 11'h1;
         ph_q <= skip ? (host_conn & host_resp) : host_conn;
         rd_ptr_q <= rd_ptr_q + 11'h1;
      end else if (pkt_ready || halt) begin
         // a taken byte, or one not yet taken while halted, is withdrawn
         pv_q <= pv_q && !pkt_ready && !halt;
         // step back so the withdrawn byte is offered again on resume
         if (halt && pv_q && !pkt_ready) begin
            rd_ptr_q <= rd_ptr_q - 11'h1;
         end
      end
   end

   // idle gap: ms prescaler restarted by every byte
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pre_q <= 15'h0;
         ms_q <= 16'h0;
      end else if (st_q != spp_pkg::spp_collect || take || idle_q == 16'h0) begin
         pre_q <= 15'h0;
         ms_q <= 16'h0;
      end else if (pre_q == 15'(MS_CYCLES - 1)) begin
         pre_q <= 15'h0;
         if (ms_q != idle_q) begin
            ms_q <= ms_q + 16'h1;
         end
      end else begin
         pre_q <= pre_q + 15'h1;
      end
   end

   // host commands and modem lines
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stb_q <= 1'b0;
         lcmd_q <= 8'h00;
      end else begin
         stb_q <= 1'b0;
         if (cmd_valid && ctrl_q[`SPP_B_DRV] && cmd_port == cport_q) begin
            stb_q <= 1'b1;
            lcmd_q <= cmd_data;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rts_q <= 1'b0;
         dtr_q <= 1'b0;
      end else begin
         rts_q <= (!link_up && !ctrl_q[`SPP_B_MSEL]) ? ctrl_q[`SPP_B_LDHI]
                  : ctrl_q[`SPP_B_RTS];
         dtr_q <= (!link_up && ctrl_q[`SPP_B_MSEL]) ? ctrl_q[`SPP_B_LDHI]
                  : ctrl_q[`SPP_B_DTR];
      end
   end

   assign s_axi_awready = aw_rdy_q;
   assign s_axi_wready = w_rdy_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = ar_rdy_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign rx_ready = rx_rdy_q;
   assign pkt_valid = pv_q;
   assign pkt_data = pd_q;
   assign pkt_last = pl_q;
   assign pkt_hosts = ph_q;
   assign ctl_cmd_stb = stb_q;
   assign ctl_cmd = lcmd_q;
   assign data_port = dport_q;
   assign cmd_listen_port = cport_q;
   assign rts = rts_q;
   assign dtr = dtr_q;

   // ---------------- checks ----------------
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   logic in_col;
   assign in_col = st_q == spp_pkg::spp_collect;
   sequence s_plain_byte;
      in_col && take && plen_q == 11'h0 && !hit && extra_q == 2'h0 && !drop
      && count_q < 11'h3ff;
   endsequence
   sequence s_two_char;
      in_col && d1en && d2en && proc == `SPP_PROC_KEEP && take && prev_d1_q
      && rx_data == delim_q[15:8];
   endsequence
   property p_zero_len;
      s_plain_byte |=> in_col && count_q == $past(count_q) + 11'h1;
   endproperty
   a_zero_len: assert property (p_zero_len) else $error("plain byte released early");
   property p_len_rel;
      in_col && take && plen_q != 11'h0 && cnt_new == plen_q
      |=> st_q == spp_pkg::spp_drain && n_q == $past(plen_q) && !rx_ready;
   endproperty
   a_len_rel: assert property (p_len_rel) else $error("length limit missed");
   property p_two_char;
      s_two_char |=> st_q == spp_pkg::spp_drain ##1 (pkt_valid || $past(halt)) [*1];
   endproperty
   a_two_char: assert property (p_two_char) else $error("delimiter pair missed");
   property p_rst_delim;
      $rose(resetn) |-> !d1en && !d2en;
   endproperty
   a_rst_delim: assert property (p_rst_delim) else $error("delimiters on at reset");
   property p_low;
      !link_up && !ctrl_q[`SPP_B_MSEL] && !ctrl_q[`SPP_B_LDHI] |=> !rts;
   endproperty
   a_low: assert property (p_low) else $error("rts not low on link loss");
   property p_high;
      !link_up && ctrl_q[`SPP_B_MSEL] && ctrl_q[`SPP_B_LDHI] |=> dtr;
   endproperty
   a_high: assert property (p_high) else $error("dtr not high on link loss");
   property p_halt;
      halt && !pkt_valid |=> !pkt_valid;
   endproperty
   a_halt: assert property (p_halt) else $error("sent while a host is stuck");
   property p_resume;
      halt && pkt_valid && !pkt_ready |=> rd_ptr_q == $past(rd_ptr_q) - 11'h1;
   endproperty
   a_resume: assert property (p_resume) else $error("withdrawn byte lost");
   property p_skip;
      load && skip |=> pkt_hosts == $past(host_conn & host_resp) && pkt_valid;
   endproperty
   a_skip: assert property (p_skip) else $error("wrong host set");
   property p_drop;
      cmd_valid && !ctrl_q[`SPP_B_DRV] |=> !ctl_cmd_stb && $stable(ctl_cmd);
   endproperty
   a_drop: assert property (p_drop) else $error("command not dropped");
   property p_accept;
      cmd_valid && ctrl_q[`SPP_B_DRV] && cmd_port == cport_q
      |=> ctl_cmd_stb && ctl_cmd == $past(cmd_data);
   endproperty
   a_accept: assert property (p_accept) else $error("command not taken");
   property p_once;
      in_col && rel && cnt_rel != 11'h0
      |=> n_q == $past(cnt_rel) && count_q == 11'h0 ##1 st_q == spp_pkg::spp_drain;
   endproperty
   a_once: assert property (p_once) else $error("release miscounted");
endmodule // spp_packer

// *** spp_far.sv ***
`timescale 1ns/1ps
module spp_far (
   input wire logic clk,
   input wire logic resetn,
   output logic rx_valid,
   output logic [7:0] rx_data,
   input wire logic rx_ready,
   input wire logic pkt_valid,
   input wire logic [7:0] pkt_data,
   input wire logic pkt_last,
   input wire logic [7:0] pkt_hosts,
   output logic pkt_ready,
   input wire logic slow
);
   // the bench loads the stream with its own delimiters
   logic [7:0] tx_q[$];
   logic [16:0] got_q[$];
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rx_valid <= 1'b0;
         rx_data <= 8'h00;
      end else if (!rx_valid || rx_ready) begin
         if (tx_q.size() > 0) begin
            rx_valid <= 1'b1;
            rx_data <= tx_q.pop_front();
         end else begin
            rx_valid <= 1'b0;
            // no stale byte left on an idle line
            rx_data <= ~rx_data;
         end
      end
   end
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pkt_ready <= 1'b0;
      end else begin
         if (pkt_valid && pkt_ready) begin
            got_q.push_back({pkt_hosts, pkt_last, pkt_data});
         end
         // a slow host takes a byte every other cycle
         pkt_ready <= slow ? !pkt_ready : 1'b1;
      end
   end
endmodule // spp_far

// *** serial_packet_packer_tb.sv ***
`timescale 1ns/1ps
`include "spp_defines.svh"
module serial_packet_packer_tb;
   localparam int MSC = 4;
   logic clk = 1'b0, resetn = 1'b0, slow = 1'b0, link_up = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, cmd_valid = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic rx_valid, rx_ready, pkt_valid, pkt_last, pkt_ready, ctl_cmd_stb, rts, dtr;
   logic [7:0] rx_data, pkt_data, pkt_hosts, ctl_cmd, cmd_data = 8'h00;
   logic [7:0] host_conn = 8'h01, host_resp = 8'h01;
   logic [15:0] cmd_port = 16'h0000, cmd_listen_port;
   logic [13:0] data_port;
   int mismatches = 0, compares = 0, cyc = 0, stb_n = 0;
   spp_packer #(.MS_CYCLES(MSC)) u_spp_packer (.clk, .resetn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .rx_valid, .rx_data, .rx_ready, .pkt_valid, .pkt_data, .pkt_last,
      .pkt_hosts, .pkt_ready, .host_conn, .host_resp, .cmd_valid, .cmd_port, .cmd_data,
      .ctl_cmd_stb, .ctl_cmd, .data_port, .cmd_listen_port, .link_up, .rts, .dtr);
   spp_far u_spp_far (.clk, .resetn, .rx_valid, .rx_data, .rx_ready, .pkt_valid,
      .pkt_data, .pkt_last, .pkt_hosts, .pkt_ready, .slow);
   always #25 clk = ~clk;
   always @(posedge clk) begin
      stb_n += ctl_cmd_stb;
      cyc++;
      if (cyc == 40000) begin
         mismatches++;
         wrap_up();
      end
   end
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      bit aw;
      bit w;
      aw = 0;
      w = 0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw && w)) begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) begin
            aw = 1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w = 1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk("bresp", 32'(s_axi_bresp), 32'(er));
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk); while (!(s_axi_arvalid && s_axi_arready));
      s_axi_arvalid <= 1'b0;
      do @(posedge clk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk("rdata", s_axi_rdata, e);
      chk("rresp", 32'(s_axi_rresp), 32'(er));
   endtask
   task automatic send(input logic [7:0] b[$]);
      foreach (b[i]) u_spp_far.tx_q.push_back(b[i]);
   endtask
   function automatic void addp(ref logic [8:0] q[$], input logic [7:0] b[$]);
      foreach (b[i]) q.push_back({i == b.size() - 1, b[i]});
   endfunction
   // waits for the whole expected stream, then looks for stray bytes
   task automatic take(input logic [8:0] e[$], input logic [7:0] hosts);
      while (u_spp_far.got_q.size() < e.size()) @(posedge clk);
      repeat (6) @(posedge clk);
      chk("pkt_count", u_spp_far.got_q.size(), e.size());
      foreach (e[i]) begin
         chk("pkt_byte", 32'(u_spp_far.got_q[i][8:0]), 32'(e[i]));
         chk("pkt_hosts", 32'(u_spp_far.got_q[i][16:9]), 32'(hosts));
      end
      u_spp_far.got_q.delete();
   endtask
   task automatic cmds(input logic [15:0] p, input logic [7:0] d[$]);
      foreach (d[i]) begin
         @(posedge clk);
         cmd_valid <= 1'b1;
         cmd_port <= p;
         cmd_data <= d[i];
      end
      @(posedge clk);
      cmd_valid <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task automatic t_reset();
      rd(`SPP_OFF_CTRL, 32'(`SPP_CTRL_RST), 2'h0);
      rd(`SPP_OFF_PLEN, 32'h0, 2'h0);
      chk("data_port", 32'(data_port), 32'(`SPP_DPORT_RST));
      chk("cmd_listen_port", 32'(cmd_listen_port), 32'(`SPP_CPORT_RST));
      chk("rts", 32'(rts), 32'h1);
      $display("test reset done");
   endtask
   task automatic t_modem();
      wr(`SPP_OFF_CTRL, 32'h000, 2'h0);
      repeat (3) @(posedge clk);
      chk("rts", 32'(rts), 32'h0);
      wr(`SPP_OFF_CTRL, 32'h280, 2'h0);
      repeat (3) @(posedge clk);
      chk("dtr", 32'(dtr), 32'h0);
      wr(`SPP_OFF_CTRL, 32'h0c0, 2'h0);
      repeat (3) @(posedge clk);
      chk("dtr", 32'(dtr), 32'h1);
      link_up <= 1'b1;
      wr(`SPP_OFF_CTRL, 32'h240, 2'h0);
      repeat (3) @(posedge clk);
      chk("dtr", 32'(dtr), 32'h1);
      chk("rts", 32'(rts), 32'h0);
      wr(`SPP_OFF_CTRL, 32'h040, 2'h0);
      $display("test modem done");
   endtask
   task automatic t_ports();
      wr(`SPP_OFF_DPORT, `SPP_DPORT_MAX, 2'h0);
      wr(`SPP_OFF_DPORT, `SPP_DPORT_MAX + 1, 2'h0);
      chk("data_port", 32'(data_port), `SPP_DPORT_MAX);
      wr(`SPP_OFF_CPORT, 32'h04d2, 2'h0);
      chk("cmd_listen_port", 32'(cmd_listen_port), 32'h04d2);
      wr(8'h20, 32'h1, 2'h2);
      rd(8'h20, 32'h0, 2'h2);
      wr(`SPP_OFF_CPORT, 32'(`SPP_CPORT_RST), 2'h0);
      $display("test ports done");
   endtask
   task automatic t_cmd();
      cmds(`SPP_CPORT_RST, '{8'h5a});
      chk("stb_off", stb_n, 0);
      wr(`SPP_OFF_CTRL, 32'h060, 2'h0);
      cmds(`SPP_CPORT_RST, '{8'h11, 8'h22});
      chk("stb_on", stb_n, 2);
      cmds(16'h0fa1, '{8'h33});
      chk("stb_port", stb_n, 2);
      chk("ctl_cmd", 32'(ctl_cmd), 32'h22);
      rd(`SPP_OFF_LCMD, 32'h22, 2'h0);
      wr(`SPP_OFF_CTRL, 32'h040, 2'h0);
      $display("test cmd done");
   endtask
   task automatic t_len();
      logic [8:0] e[$];
      wr(`SPP_OFF_PLEN, 32'h3, 2'h0);
      wr(`SPP_OFF_IDLE, 32'h1, 2'h0);
      send('{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07});
      addp(e, '{8'h01, 8'h02, 8'h03});
      addp(e, '{8'h04, 8'h05, 8'h06});
      addp(e, '{8'h07});
      take(e, 8'h01);
      wr(`SPP_OFF_IDLE, 32'h0, 2'h0);
      wr(`SPP_OFF_PLEN, 32'h0, 2'h0);
      $display("test length done");
   endtask
   task automatic t_delim();
      logic [7:0] src[4] = '{8'h11, 8'h0d, 8'h22, 8'h33};
      logic [7:0] b[$];
      logic [8:0] e[$];
      // length limit already zero before the first delimiter goes on
      wr(`SPP_OFF_DELIM, 32'h0d, 2'h0);
      for (int m = 0; m < 4; m++) begin
         b.delete();
         e.delete();
         for (int i = 0; i < ((m == 3) ? 2 : 2 + m); i++) b.push_back(src[i]);
         wr(`SPP_OFF_CTRL, 32'h041 | (m << 2), 2'h0);
         send(b);
         if (m == 3) begin
            addp(e, '{8'h11});
         end else begin
            addp(e, b);
         end
         take(e, 8'h01);
      end
      wr(`SPP_OFF_CTRL, 32'h043, 2'h0);
      wr(`SPP_OFF_DELIM, 32'h0a0d, 2'h0);
      send('{8'h0d, 8'h55, 8'h0d, 8'h0a});
      e.delete();
      addp(e, '{8'h0d, 8'h55, 8'h0d, 8'h0a});
      take(e, 8'h01);
      wr(`SPP_OFF_CTRL, 32'h04f, 2'h0);
      send('{8'h0d, 8'h55, 8'h0d, 8'h0a});
      e.delete();
      addp(e, '{8'h0d, 8'h55});
      take(e, 8'h01);
      wr(`SPP_OFF_CTRL, 32'h040, 2'h0);
      $display("test delimiter done");
   endtask
   task automatic t_full();
      logic [7:0] b[$];
      logic [8:0] e[$];
      for (int i = 0; i < 1024; i++) b.push_back(8'(i));
      for (int p = 0; p <= 1024; p += 1024) begin
         e.delete();
         wr(`SPP_OFF_PLEN, 32'(p), 2'h0);
         send(b);
         addp(e, b);
         take(e, 8'h01);
      end
      wr(`SPP_OFF_PLEN, 32'h0, 2'h0);
      $display("test full done");
   endtask
   task automatic t_halt();
      logic [8:0] e[$];
      wr(`SPP_OFF_PLEN, 32'h2, 2'h0);
      host_conn <= 8'h03;
      send('{8'ha1, 8'ha2});
      repeat (30) @(posedge clk);
      chk("halted", u_spp_far.got_q.size(), 0);
      host_resp <= 8'h03;
      addp(e, '{8'ha1, 8'ha2});
      take(e, 8'h03);
      wr(`SPP_OFF_CTRL, 32'h050, 2'h0);
      host_resp <= 8'h01;
      slow <= 1'b1;
      send('{8'hb1, 8'hb2});
      e.delete();
      addp(e, '{8'hb1, 8'hb2});
      take(e, 8'h01);
      slow <= 1'b0;
      $display("test halt done");
   endtask
   task automatic wrap_up();
      $display("counts: %0d compares, %0d mismatches", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset();
      t_modem();
      t_ports();
      t_cmd();
      t_len();
      t_delim();
      t_full();
      t_halt();
      wrap_up();
   end
endmodule // serial_packet_packer_tb
